// *** verilog/plcr_pkg.sv ***
// constants for the peripheral local control register bank
package plcr_pkg;
	// register indices (printed byte offsets are not word aligned)
	localparam logic [31:0] PLCR_IDX_BERR_CTRL  = 32'hFFFE1022;
	localparam logic [31:0] PLCR_IDX_DMA_STAT   = 32'hFFFE1023;
	localparam logic [31:0] PLCR_IDX_ABORT_CTRL = 32'hFFFE1024;
	localparam logic [31:0] PLCR_IDX_TBL_FC     = 32'hFFFE1025;
	localparam logic [31:0] PLCR_IDX_SER_CTRL   = 32'hFFFE1026;
	localparam logic [31:0] PLCR_IDX_GEN_CTRL   = 32'hFFFE1027;
	localparam int          PLCR_IDX_BASE_BIT   = 2;
	// field positions
	localparam int PLCR_BIT_STAT    = 7;
	localparam int PLCR_BIT_ABORT   = 6;
	localparam int PLCR_BIT_VECSRC  = 4;
	localparam int PLCR_BIT_ENABLE  = 3;
	localparam int PLCR_BIT_PTEST   = 2;
	localparam int PLCR_BIT_LBTO    = 3;
	localparam int PLCR_BIT_GIE     = 4;
	localparam int PLCR_LSB_LOCKOUT = 5;
	// values and reset values
	localparam logic [2:0] PLCR_LOCKOUT_KEY   = 3'h5;
	localparam logic [2:0] PLCR_LEVEL_NONE    = 3'h0;
	localparam logic [2:0] PLCR_LEVEL_FIXED   = 3'h7;
	localparam logic [7:0] PLCR_RESET_BYTE    = 8'h00;
	localparam logic [1:0] PLCR_PAR_OFF0      = 2'h0;
	localparam logic [1:0] PLCR_PAR_NOW       = 2'h1;
	localparam logic [1:0] PLCR_PAR_OFF2      = 2'h2;
	localparam logic [1:0] PLCR_PAR_STICKY    = 2'h3;
	// parity mode decode
	typedef enum logic [1:0] {
		PLCR_PM_OFF    = 2'b00,
		PLCR_PM_NOW    = 2'b01,
		PLCR_PM_STICKY = 2'b10
	} plcr_pmode_t;
endpackage

// *** verilog/plcr_sync.sv ***
// two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module plcr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// first stage is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// *** verilog/plcr_regs.sv ***
// peripheral local control register bank with apb slave
`timescale 1ns/1ps
module plcr_regs
	import plcr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cpu_bus_error,
	input  wire logic        abort_button,
	input  wire logic        serial_chip_irq,
	input  wire logic        dma_enable,
	input  wire logic [3:0]  hold_byte_full,
	input  wire logic        dma_count_step,
	input  wire logic [1:0]  dma_step_size,
	input  wire logic        dma_table_access,
	input  wire logic        dram_access,
	input  wire logic        dram_by_cpu,
	input  wire logic        dram_parity_error,
	output logic             berr_irq,
	output logic             abort_irq,
	output logic             serial_irq,
	output logic [2:0]       serial_irq_level,
	output logic             serial_vector_local,
	output logic [2:0]       fixed_irq_level,
	output logic [2:0]       table_walk_fc,
	output logic             table_walk_fc_valid,
	output logic             dram_bus_error,
	output logic             dram_extra_wait,
	output logic             parity_test_invert,
	output logic             local_bus_timer_enable,
	output logic             reset_switch_enable
);
	// synchronised pins
	logic [2:0] pin_sync;
	logic       abort_pressed;
	logic       serial_req;
	logic       cpu_berr;

	plcr_sync #(
		.WIDTH (3)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({abort_button, serial_chip_irq, cpu_bus_error}),
		.sync_out (pin_sync)
	);
	assign abort_pressed = pin_sync[2];
	assign serial_req    = pin_sync[1];
	assign cpu_berr      = pin_sync[0];

	// register state
	logic       berr_en_reg;
	logic       berr_stat_reg;
	logic       abort_en_reg;
	logic       abort_stat_reg;
	logic       abort_arm_reg;
	logic [3:0] hold_full_reg;
	logic [3:0] step_reg;
	logic [2:0] tbl_fc_reg;
	logic [2:0] ser_level_reg;
	logic       ser_en_reg;
	logic       ser_vec_reg;
	logic       ser_stat_reg;
	logic [7:0] gen_reg;
	logic       cpu_par_sticky_reg;

	// bus decode
	logic       wr_fire;
	logic       rd_fire;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic       hit;

	// true when the word address matches a register index
	function automatic logic idx_hit(input logic [31:0] addr, input logic [31:0] idx);
		logic [31:0] byte_addr;
		byte_addr = {idx[29:0], 2'b00};
		return addr == byte_addr;
	endfunction

	// step size one-hot decode
	function automatic logic [3:0] step_onehot(input logic [1:0] sz);
		logic [3:0] oh;
		oh = 4'h0;
		oh[sz] = 1'b1;
		return oh;
	endfunction

	// parity mode decode
	function automatic plcr_pmode_t pmode(input logic [1:0] field);
		plcr_pmode_t m;
		m = PLCR_PM_OFF;
		if (field == PLCR_PAR_NOW) begin
			m = PLCR_PM_NOW;
		end else if (field == PLCR_PAR_STICKY) begin
			m = PLCR_PM_STICKY;
		end
		return m;
	endfunction

	// access-phase write strobe and read select
	assign wr_fire = psel && penable && pwrite;
	assign rd_fire = psel && !pwrite;
	assign wbyte   = pwdata[7:0];

	// read mux
	always_comb begin
		hit   = 1'b1;
		// reserved bits read as zero
		rbyte = PLCR_RESET_BYTE;
		if (idx_hit(paddr, PLCR_IDX_BERR_CTRL)) begin
			rbyte[PLCR_BIT_STAT]   = berr_stat_reg;
			rbyte[PLCR_BIT_ENABLE] = berr_en_reg;
		end else if (idx_hit(paddr, PLCR_IDX_DMA_STAT)) begin
			rbyte = {step_reg, hold_full_reg};
		end else if (idx_hit(paddr, PLCR_IDX_ABORT_CTRL)) begin
			rbyte[PLCR_BIT_STAT]   = abort_stat_reg;
			rbyte[PLCR_BIT_ABORT]  = abort_pressed;
			rbyte[PLCR_BIT_ENABLE] = abort_en_reg;
		end else if (idx_hit(paddr, PLCR_IDX_TBL_FC)) begin
			rbyte[2:0] = tbl_fc_reg;
		end else if (idx_hit(paddr, PLCR_IDX_SER_CTRL)) begin
			rbyte[PLCR_BIT_STAT]   = ser_stat_reg;
			rbyte[PLCR_BIT_VECSRC] = ser_vec_reg;
			rbyte[PLCR_BIT_ENABLE] = ser_en_reg;
			rbyte[2:0]             = ser_level_reg;
		end else if (idx_hit(paddr, PLCR_IDX_GEN_CTRL)) begin
			rbyte = gen_reg;
		end else begin
			hit = 1'b0;
		end
	end

	// apb answer: zero wait, registered from the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			if (psel && !penable && rd_fire) begin
				prdata <= {24'h00_0000, rbyte};
			end
		end
	end

	// write commit happens at the edge that samples pready
	logic commit;
	assign commit = wr_fire && pready && hit;

	// bus error interrupt control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			berr_en_reg   <= 1'b0;
			berr_stat_reg <= 1'b0;
		end else begin
			if (commit && idx_hit(paddr, PLCR_IDX_BERR_CTRL)) begin
				berr_en_reg <= wbyte[PLCR_BIT_ENABLE];
			end
			// set is tested before the write-one clear so a fresh error is never lost
			if (!berr_en_reg) begin
				berr_stat_reg <= 1'b0;
			end else if (cpu_berr) begin
				berr_stat_reg <= 1'b1;
			end else if (commit && idx_hit(paddr, PLCR_IDX_BERR_CTRL) && wbyte[PLCR_BIT_STAT]) begin
				berr_stat_reg <= 1'b0;
			end
		end
	end

	// abort interrupt control, edge of enable and press
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_en_reg   <= 1'b0;
			abort_stat_reg <= 1'b0;
			abort_arm_reg  <= 1'b0;
		end else begin
			if (commit && idx_hit(paddr, PLCR_IDX_ABORT_CTRL)) begin
				abort_en_reg <= wbyte[PLCR_BIT_ENABLE];
			end
			// arm holds the previous level so only a leading edge sets status
			abort_arm_reg <= abort_en_reg && abort_pressed;
			if (!abort_en_reg) begin
				abort_stat_reg <= 1'b0;
			end else if (abort_pressed && !abort_arm_reg) begin
				abort_stat_reg <= 1'b1;
			end else if (commit && idx_hit(paddr, PLCR_IDX_ABORT_CTRL) && wbyte[PLCR_BIT_STAT]) begin
				abort_stat_reg <= 1'b0;
			end
		end
	end

	// dma status capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_full_reg <= 4'h0;
			step_reg      <= 4'h0;
		end else if (!dma_enable) begin
			hold_full_reg <= 4'h0;
			step_reg      <= 4'h0;
		end else begin
			hold_full_reg <= hold_byte_full;
			if (dma_count_step) begin
				step_reg <= step_onehot(dma_step_size);
			end
		end
	end

	// table function code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_fc_reg <= 3'h0;
		end else if (commit && idx_hit(paddr, PLCR_IDX_TBL_FC)) begin
			tbl_fc_reg <= wbyte[2:0];
		end
	end

	// serial interrupt control and level status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_level_reg <= 3'h0;
			ser_en_reg    <= 1'b0;
			ser_vec_reg   <= 1'b0;
			ser_stat_reg  <= 1'b0;
		end else begin
			if (commit && idx_hit(paddr, PLCR_IDX_SER_CTRL)) begin
				ser_level_reg <= wbyte[2:0];
				ser_en_reg    <= wbyte[PLCR_BIT_ENABLE];
				ser_vec_reg   <= wbyte[PLCR_BIT_VECSRC];
			end
			ser_stat_reg <= ser_en_reg && serial_req;
		end
	end

	// general control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_reg <= PLCR_RESET_BYTE;
		end else if (commit && idx_hit(paddr, PLCR_IDX_GEN_CTRL)) begin
			gen_reg <= wbyte;
		end
	end

	// sticky processor parity fault for mode 3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_par_sticky_reg <= 1'b0;
		end else if (pmode(gen_reg[1:0]) != PLCR_PM_STICKY) begin
			cpu_par_sticky_reg <= 1'b0;
		end else if (dram_access && dram_by_cpu && dram_parity_error) begin
			cpu_par_sticky_reg <= 1'b1;
		end
	end

	// dram parity bus error and wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dram_bus_error  <= 1'b0;
			dram_extra_wait <= 1'b0;
		end else begin
			unique case (pmode(gen_reg[1:0]))
				PLCR_PM_OFF: begin
					dram_bus_error  <= 1'b0;
					dram_extra_wait <= 1'b0;
				end
				PLCR_PM_NOW: begin
					dram_bus_error  <= dram_access && dram_parity_error;
					dram_extra_wait <= dram_access;
				end
				// other masters see the error at once with one wait;
				// the processor only from its next dram cycle on
				PLCR_PM_STICKY: begin
					dram_extra_wait <= dram_access && !dram_by_cpu;
					dram_bus_error  <= dram_access && (dram_by_cpu ? cpu_par_sticky_reg
						: dram_parity_error);
				end
				default: begin
					dram_bus_error  <= 1'b0;
					dram_extra_wait <= 1'b0;
				end
			endcase
		end
	end

	// interrupt requests and misc control outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			berr_irq               <= 1'b0;
			abort_irq              <= 1'b0;
			serial_irq             <= 1'b0;
			serial_irq_level       <= 3'h0;
			serial_vector_local    <= 1'b0;
			fixed_irq_level        <= PLCR_LEVEL_FIXED;
			table_walk_fc          <= 3'h0;
			table_walk_fc_valid    <= 1'b0;
			parity_test_invert     <= 1'b0;
			local_bus_timer_enable <= 1'b0;
			reset_switch_enable    <= 1'b1;
		end else begin
			berr_irq   <= berr_stat_reg && berr_en_reg && gen_reg[PLCR_BIT_GIE];
			abort_irq  <= abort_stat_reg && abort_en_reg && gen_reg[PLCR_BIT_GIE];
			serial_irq <= ser_stat_reg && ser_en_reg && gen_reg[PLCR_BIT_GIE]
				&& (ser_level_reg != PLCR_LEVEL_NONE);
			serial_irq_level       <= ser_level_reg;
			serial_vector_local    <= ser_vec_reg;
			fixed_irq_level        <= PLCR_LEVEL_FIXED;
			table_walk_fc          <= dma_table_access ? tbl_fc_reg : 3'h0;
			table_walk_fc_valid    <= dma_table_access;
			parity_test_invert     <= gen_reg[PLCR_BIT_PTEST];
			local_bus_timer_enable <= gen_reg[PLCR_BIT_LBTO];
			reset_switch_enable    <= gen_reg[PLCR_LSB_LOCKOUT +: 3] != PLCR_LOCKOUT_KEY;
		end
	end
endmodule

// *** testbench/plcr_regs_monitor.sv ***
// port-level assertions for the local control register bank
`timescale 1ns/1ps
module plcr_regs_monitor
	import plcr_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_chip_irq,
	input wire logic        dma_table_access,
	input wire logic        dram_access,
	input wire logic        berr_irq,
	input wire logic        abort_irq,
	input wire logic        serial_irq,
	input wire logic [2:0]  serial_irq_level,
	input wire logic [2:0]  fixed_irq_level,
	input wire logic        table_walk_fc_valid,
	input wire logic        dram_bus_error,
	input wire logic        dram_extra_wait
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] s_age;
	// cycles since the serial request pin was last high, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_age <= 3'h7;
		end else if (serial_chip_irq) begin
			s_age <= 3'h0;
		end else if (s_age != 3'h7) begin
			s_age <= s_age + 3'h1;
		end
	end
	property p_lvl; fixed_irq_level == PLCR_LEVEL_FIXED; endproperty
	property p_slvl; serial_irq |-> serial_irq_level != PLCR_LEVEL_NONE; endproperty
	property p_sreq; serial_irq |-> s_age < 3'h6; endproperty
	property p_fcv; !dma_table_access [*2] |-> !table_walk_fc_valid; endproperty
	property p_dram; !dram_access |=> !dram_bus_error && !dram_extra_wait; endproperty
	property p_rdy; psel && !penable |=> pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_rd0; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_lvl: assert property (p_lvl) else $error("fixed level not 7");
	a_slvl: assert property (p_slvl) else $error("serial irq at level 0");
	a_sreq: assert property (p_sreq) else $error("serial irq without request");
	a_fcv: assert property (p_fcv) else $error("fc driven outside walk");
	a_dram: assert property (p_dram) else $error("dram error without access");
	a_rdy: assert property (p_rdy) else $error("no pready after setup");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_rd0: assert property (p_rd0) else $error("upper read bits set");
	c_berr: cover property (berr_irq);
	c_abort: cover property (abort_irq);
	c_ser: cover property (serial_irq);
	c_dram: cover property (dram_bus_error);
endmodule
bind plcr_regs plcr_regs_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_chip_irq(serial_chip_irq),
	.dma_table_access(dma_table_access), .dram_access(dram_access), .berr_irq(berr_irq), .abort_irq(abort_irq),
	.serial_irq(serial_irq), .serial_irq_level(serial_irq_level), .fixed_irq_level(fixed_irq_level),
	.table_walk_fc_valid(table_walk_fc_valid), .dram_bus_error(dram_bus_error), .dram_extra_wait(dram_extra_wait));

// *** testbench/plcr_dma_model.sv ***
// dma engine stand-in that steps the counters on request
`timescale 1ns/1ps
module plcr_dma_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [1:0] size,
	output logic            dma_count_step,
	output logic [1:0]      dma_step_size
);
	// one step pulse per request; size wanders between steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_count_step <= 1'b0;
			dma_step_size  <= 2'h0;
		end else begin
			dma_count_step <= go;
			dma_step_size  <= go ? size : ~dma_step_size;
		end
	end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the local control register bank
`timescale 1ns/1ps
module tb_top;
	import plcr_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, r;
	logic        cpu_bus_error = 0, abort_button = 0, serial_chip_irq = 0, dma_enable = 0, se;
	logic [3:0]  hold_byte_full = '0;
	logic [1:0]  size = '0, dma_step_size;
	logic        dma_table_access = 0, dram_access = 0, dram_by_cpu = 0, dram_parity_error = 0;
	logic        pready, pslverr, berr_irq, abort_irq, serial_irq, serial_vector_local, dma_count_step;
	logic [2:0]  serial_irq_level, fixed_irq_level, table_walk_fc;
	logic        table_walk_fc_valid, dram_bus_error, dram_extra_wait, parity_test_invert;
	logic        local_bus_timer_enable, reset_switch_enable;
	int          failures = 0, num_checks = 0, cyc = 0;
	logic [2:0]  fcv [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
	plcr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_bus_error(cpu_bus_error), .abort_button(abort_button), .serial_chip_irq(serial_chip_irq),
		.dma_enable(dma_enable), .hold_byte_full(hold_byte_full), .dma_count_step(dma_count_step),
		.dma_step_size(dma_step_size), .dma_table_access(dma_table_access), .dram_access(dram_access),
		.dram_by_cpu(dram_by_cpu), .dram_parity_error(dram_parity_error), .berr_irq(berr_irq),
		.abort_irq(abort_irq), .serial_irq(serial_irq), .serial_irq_level(serial_irq_level),
		.serial_vector_local(serial_vector_local), .fixed_irq_level(fixed_irq_level),
		.table_walk_fc(table_walk_fc), .table_walk_fc_valid(table_walk_fc_valid),
		.dram_bus_error(dram_bus_error), .dram_extra_wait(dram_extra_wait),
		.parity_test_invert(parity_test_invert), .local_bus_timer_enable(local_bus_timer_enable),
		.reset_switch_enable(reset_switch_enable));
	plcr_dma_model u_dma (.pclk(pclk), .presetn(presetn), .go(go), .size(size),
		.dma_count_step(dma_count_step), .dma_step_size(dma_step_size));
	// clock and hang guard
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			complete_run();
		end
	end
	task complete_run();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			failures++;
		end
	endtask
	// one apb transfer; the request is held until pready is seen
	task apb(input logic w, input logic [31:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= i << PLCR_IDX_BASE_BIT;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the edge that samples pready high; the hang guard ends a stuck wait
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r  = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [31:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask
	task rd(input logic [31:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk($sformatf("reg %h", i), {24'h0, e}, r);
	endtask
	// lets pin changes cross the input synchroniser
	task hold();
		repeat (6) @(posedge pclk);
	endtask
	task dr(input logic c, input logic e, input logic b, input logic [1:0] ew);
		@(posedge pclk);
		dram_access       <= 1'b1;
		dram_by_cpu       <= c;
		dram_parity_error <= e;
		@(posedge pclk);
		dram_access       <= 1'b0;
		dram_parity_error <= 1'b0;
		@(negedge pclk);
		chk("dram_bus_error", 32'(b), 32'(dram_bus_error));
		if (ew != 2'h2) chk("dram_extra_wait", 32'(ew[0]), 32'(dram_extra_wait));
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 6; k++) rd(PLCR_IDX_BERR_CTRL + k, 8'h00);
		rd(32'hFFFE1028, 8'h00);
		chk("pslverr", 1, 32'(se));
		chk("lock", 1, 32'(reset_switch_enable));
		chk("fixed_lvl", 32'h7, 32'(fixed_irq_level));
		// bus error: set, write-one clear, global mask, disable clear
		wr(PLCR_IDX_GEN_CTRL, 8'h10);
		wr(PLCR_IDX_BERR_CTRL, 8'h08);
		for (int k = 0; k < 2; k++) begin
			@(posedge pclk) cpu_bus_error <= 1'b1;
			@(posedge pclk) cpu_bus_error <= 1'b0;
			hold();
			rd(PLCR_IDX_BERR_CTRL, 8'h88);
			chk("berr_irq", 32'(k == 0), 32'(berr_irq));
			wr(PLCR_IDX_BERR_CTRL, 8'h88);
			rd(PLCR_IDX_BERR_CTRL, 8'h08);
			wr(PLCR_IDX_GEN_CTRL, 8'h00);
		end
		@(posedge pclk) cpu_bus_error <= 1'b1;
		@(posedge pclk) cpu_bus_error <= 1'b0;
		hold();
		rd(PLCR_IDX_BERR_CTRL, 8'h88);
		wr(PLCR_IDX_BERR_CTRL, 8'h00);
		rd(PLCR_IDX_BERR_CTRL, 8'h00);
		wr(PLCR_IDX_GEN_CTRL, 8'h10);
		// abort: live bit, edge on enable while held, stays clear
		@(posedge pclk) abort_button <= 1'b1;
		hold();
		rd(PLCR_IDX_ABORT_CTRL, 8'h40);
		wr(PLCR_IDX_ABORT_CTRL, 8'h08);
		hold();
		rd(PLCR_IDX_ABORT_CTRL, 8'hC8);
		chk("abort_irq", 1, 32'(abort_irq));
		wr(PLCR_IDX_ABORT_CTRL, 8'hC8);
		hold();
		rd(PLCR_IDX_ABORT_CTRL, 8'h48);
		chk("abort_irq", 0, 32'(abort_irq));
		@(posedge pclk) abort_button <= 1'b0;
		hold();
		rd(PLCR_IDX_ABORT_CTRL, 8'h08);
		// serial: level sensitive status, level and vector source
		@(posedge pclk) serial_chip_irq <= 1'b1;
		wr(PLCR_IDX_SER_CTRL, 8'h1B);
		hold();
		rd(PLCR_IDX_SER_CTRL, 8'h9B);
		chk("serial", 32'h1B, {27'h0, serial_irq, serial_vector_local, serial_irq_level});
		wr(PLCR_IDX_SER_CTRL, 8'h08);
		hold();
		chk("serial", 32'h0, {30'h0, serial_irq, serial_vector_local});
		@(posedge pclk) serial_chip_irq <= 1'b0;
		hold();
		rd(PLCR_IDX_SER_CTRL, 8'h08);
		// table walk function codes
		@(posedge pclk) dma_table_access <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(PLCR_IDX_TBL_FC, {5'h0, fcv[k]});
			rd(PLCR_IDX_TBL_FC, {5'h0, fcv[k]});
			chk("fc", {28'h1, fcv[k]}, {28'(table_walk_fc_valid), table_walk_fc});
		end
		@(posedge pclk) dma_table_access <= 1'b0;
		repeat (2) @(negedge pclk);
		chk("fc_idle", 32'h0, {28'(table_walk_fc_valid), table_walk_fc});
		// dma status: byte flags and every step size, then disable
		@(posedge pclk) dma_enable <= 1'b1;
		hold_byte_full <= 4'hA;
		for (int k = 0; k < 4; k++) begin
			@(posedge pclk) go <= 1'b1;
			size <= 2'(k);
			@(posedge pclk) go <= 1'b0;
			rd(PLCR_IDX_DMA_STAT, {4'(1 << k), 4'hA});
		end
		@(posedge pclk) dma_enable <= 1'b0;
		rd(PLCR_IDX_DMA_STAT, 8'h00);
		// reset switch lockout over every pattern
		for (int v = 0; v < 8; v++) begin
			wr(PLCR_IDX_GEN_CTRL, {3'(v), 5'h0C});
			repeat (2) @(negedge pclk);
			chk("lock", 32'(v != 5), 32'(reset_switch_enable));
		end
		chk("test_tmr", 32'h3, {30'h0, parity_test_invert, local_bus_timer_enable});
		rd(PLCR_IDX_GEN_CTRL, 8'hEC);
		// parity modes; dram counts as fully written, so errors come only when injected, except the mode 3 sticky processor error on its next cycle
		wr(PLCR_IDX_GEN_CTRL, 8'h13);
		dr(1, 1, 0, 2'h0);
		dr(1, 0, 1, 2'h0);
		dr(0, 1, 1, 2'h1);
		wr(PLCR_IDX_GEN_CTRL, 8'h11);
		dr(0, 1, 1, 2'h1);
		dr(1, 0, 0, 2'h1);
		wr(PLCR_IDX_GEN_CTRL, 8'h12);
		dr(1, 1, 0, 2'h0);
		wr(PLCR_IDX_GEN_CTRL, 8'h10);
		dr(0, 1, 0, 2'h0);
		wr(PLCR_IDX_GEN_CTRL, 8'h13);
		dr(1, 0, 0, 2'h0);
		complete_run();
	end
endmodule
